// *** scr_chk_sva.sv ***
// Checker for the system configuration register bank
`timescale 1ns/1ps
`default_nettype none
module scr_chk (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [31:0] osc_select_config_word,
  input wire logic [31:0] code_protect_word,
  input wire logic [2:0]  startup_src,
  input wire logic        code_protect_en,
  input wire logic [31:0] ram_exec_base,
  input wire logic        debug_port_enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Completed accesses and expected outputs
  wire        go = psel && penable && pready;
  wire        wr = go && pwrite && paddr == 32'h3B00;
  wire        rd = go && !pwrite;
  wire [31:0] eb = {14'h2800, pwdata[23:16], 10'h0};
  wire [31:0] ow = osc_select_config_word;
  wire [2:0]  s = ow[2:0];
  wire [2:0]  src = s == 3'h1 ? (ow[4] ? 3'h1 : 3'h2) : s == 3'h2 ? 3'h3 : s == 3'h3 ? 3'h7 :
                    s[2] && s[1] ? 3'h0 : s;
  a_ready_next: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("late ready");
  a_exec_base: assert property (wr |-> ##2 ram_exec_base == $past(eb, 2))
    else $error("bad exec base");
  a_dbg_write: assert property (wr |-> ##2 debug_port_enable == $past(pwdata[3], 2))
    else $error("bad debug enable");
  a_exec_hold: assert property ($changed(ram_exec_base) |-> $past(wr) || $past(wr, 2))
    else $error("exec base moved");
  a_ctrl_zero: assert property (rd && paddr == 32'h3B00 |-> (prdata & 32'hF400FFF0) == 0)
    else $error("unused bit set");
  a_key_hidden: assert property (rd && paddr == 32'h3B30 |-> prdata == 32'h0)
    else $error("key readable");
  a_prot_map: assert property ($stable(code_protect_word) [*5] |-> code_protect_en == !code_protect_word[31])
    else $error("bad protect flag");
  a_osc_source: assert property ($stable(ow) [*5] |-> startup_src == src)
    else $error("bad source");
endmodule
bind scr_regs scr_chk i_chk (
  .mclk                   (mclk),
  .rst_n                  (rst_n),
  .psel                   (psel),
  .penable                (penable),
  .pwrite                 (pwrite),
  .paddr                  (paddr),
  .pwdata                 (pwdata),
  .prdata                 (prdata),
  .pready                 (pready),
  .osc_select_config_word (osc_select_config_word),
  .code_protect_word      (code_protect_word),
  .startup_src            (startup_src),
  .code_protect_en        (code_protect_en),
  .ram_exec_base          (ram_exec_base),
  .debug_port_enable      (debug_port_enable)
);
`default_nettype wire

// *** scr_consts.vh ***
// Constants for the system configuration register bank
`ifndef SCR_CONSTS_VH
`define SCR_CONSTS_VH

// Register byte offsets
`define SCR_OFF_CFG_CTRL      14'h3B00
`define SCR_OFF_DEV_ID        14'h3B20
`define SCR_OFF_UNLOCK_KEY    14'h3B30
`define SCR_OFF_OSC_WORD      14'h3B40
`define SCR_OFF_PROTECT_WORD  14'h3B44
`define SCR_OFF_STARTUP       14'h3B48
`define SCR_ADDR_W            14

// Oscillator select codes
`define SCR_OSC_FRC_DIV       3'h0
`define SCR_OSC_PLL           3'h1
`define SCR_OSC_PRIMARY       3'h2
`define SCR_OSC_RSVD          3'h3
`define SCR_OSC_SECONDARY     3'h4
`define SCR_OSC_LOW_POWER_RC_OSC          3'h5

// Startup clock source encodings, one binary code per source
`define SCR_SRC_FRC_DIV       3'h0
`define SCR_SRC_PLL_FRC       3'h1
`define SCR_SRC_PLL_PRI       3'h2
`define SCR_SRC_PRIMARY       3'h3
`define SCR_SRC_SECONDARY     3'h4
`define SCR_SRC_LOW_POWER_RC_OSC          3'h5
`define SCR_SRC_NONE          3'h7

// Field positions
`define SCR_OSC_SEL_HI        2
`define SCR_OSC_SEL_LO        0
`define SCR_PLL_REF_BIT       4
`define SCR_PROTECT_BIT       31
`define SCR_EXEC_HI           23
`define SCR_EXEC_LO           16
`define SCR_DBG_EN_BIT        3
`define SCR_DBG_CFG_BIT       2
`define SCR_CFG_RSVD27        27
`define SCR_CFG_RSVD_HI       25
`define SCR_CFG_RSVD_LO       24
`define SCR_CFG_RSVD_ONES     2'h3

// Reset values and RAM window
`define SCR_EXEC_RST          8'h00
`define SCR_KEY_RST           32'h00000000
`define SCR_RAM_BASE          32'hA0000000
`define SCR_KB_SHIFT          10
`define SCR_ZERO32            32'h00000000

// Edges to wait after reset before the synchronised debug word is valid
`define SCR_LOAD_WAIT         2'h2
`define SCR_LOAD_STEP         2'h1
`define SCR_LOAD_DONE         2'h0

`endif

// *** scr_osc_decode.v ***
// Startup oscillator source decoder
`timescale 1ns/1ps
`default_nettype none
`include "scr_consts.vh"

module scr_osc_decode (
  input  wire [2:0] osc_sel,
  input  wire       pll_ref_sel,
  output reg  [2:0] src
);

  // Map the select field and PLL reference bit to one source code
  always @* begin
    case (osc_sel)
      `SCR_OSC_FRC_DIV:   src = `SCR_SRC_FRC_DIV;
      `SCR_OSC_PLL:       src = pll_ref_sel ? `SCR_SRC_PLL_FRC : `SCR_SRC_PLL_PRI;
      `SCR_OSC_PRIMARY:   src = `SCR_SRC_PRIMARY;
      `SCR_OSC_RSVD:      src = `SCR_SRC_NONE;
      `SCR_OSC_SECONDARY: src = `SCR_SRC_SECONDARY;
      `SCR_OSC_LOW_POWER_RC_OSC:      src = `SCR_SRC_LOW_POWER_RC_OSC;
      default:            src = `SCR_SRC_FRC_DIV;
    endcase
  end

endmodule
`default_nettype wire

// *** scr_regs.v ***
// APB register bank for system configuration and control
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "scr_consts.vh"

module scr_regs #(
  parameter [3:0]  REVISION  = 4'h1,       // Arbitrary value
  parameter [27:0] DEVICE_ID = 28'h0000ABC // Arbitrary value
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [31:0] osc_select_config_word,
  input  wire [31:0] code_protect_word,
  input  wire [31:0] debug_config_word,
  output reg  [2:0]  startup_src,
  output reg         code_protect_en,
  output reg  [31:0] ram_exec_base,
  output reg         debug_port_enable,
  output reg  [31:0] system_unlock_key,
  output reg         key_written
);

  reg  [7:0]  ram_exec_q;
  reg         dbg_en_q;
  reg         load_q;
  reg  [1:0]  load_cnt_q;
  reg  [31:0] osc_q;
  reg  [31:0] prot_q;
  reg  [31:0] dbg_cfg_s1_q;
  reg  [31:0] dbg_cfg_q;
  reg  [31:0] osc_s1_q;
  reg  [31:0] prot_s1_q;
  reg  [31:0] rd_d;
  reg         err_d;
  wire [2:0]  src_d;
  wire [`SCR_ADDR_W-1:0] addr;
  wire        access;
  wire        wr;

  assign addr   = paddr[`SCR_ADDR_W-1:0];
  assign access = psel & penable & ~pready;
  assign wr     = access & pwrite;

  // Configuration words come from nonvolatile memory; bring them in through two flops
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_q     <= `SCR_ZERO32;
      osc_q        <= `SCR_ZERO32;
      prot_s1_q    <= `SCR_ZERO32;
      prot_q       <= `SCR_ZERO32;
      dbg_cfg_s1_q <= `SCR_ZERO32;
      dbg_cfg_q    <= `SCR_ZERO32;
    end else begin
      osc_s1_q     <= osc_select_config_word;
      osc_q        <= osc_s1_q;
      prot_s1_q    <= code_protect_word;
      prot_q       <= prot_s1_q;
      dbg_cfg_s1_q <= debug_config_word;
      dbg_cfg_q    <= dbg_cfg_s1_q;
    end
  end

  // Decode the startup source from the latched oscillator word
  scr_osc_decode u_dec (
    .osc_sel     (osc_q[`SCR_OSC_SEL_HI:`SCR_OSC_SEL_LO]),
    .pll_ref_sel (osc_q[`SCR_PLL_REF_BIT]),
    .src         (src_d)
  );

  // Read mux; unimplemented and reserved control bits return zero
  always @* begin
    rd_d  = `SCR_ZERO32;
    err_d = 1'b0;
    case (addr)
      `SCR_OFF_CFG_CTRL: begin
        rd_d[`SCR_EXEC_HI:`SCR_EXEC_LO] = ram_exec_q;
        rd_d[`SCR_DBG_EN_BIT]           = dbg_en_q;
      end
      `SCR_OFF_DEV_ID:       rd_d = {REVISION, DEVICE_ID};
      `SCR_OFF_UNLOCK_KEY:   rd_d = `SCR_ZERO32;
      `SCR_OFF_OSC_WORD:     rd_d = osc_q;
      `SCR_OFF_PROTECT_WORD: rd_d = prot_q;
      `SCR_OFF_STARTUP:      rd_d = {29'h0000000, src_d};
      default:               err_d = 1'b1;
    endcase
    if (paddr[31:`SCR_ADDR_W] != 18'h00000) begin
      err_d = 1'b1;
    end
  end

  // APB slave: one wait state, answer in the cycle after access begins
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `SCR_ZERO32;
    end else begin
      pready  <= access;
      pslverr <= access & err_d;
      if (access && !pwrite) begin
        prdata <= err_d ? `SCR_ZERO32 : rd_d;
      end
    end
  end

  // Writable fields; identity writes fall through untouched
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ram_exec_q        <= `SCR_EXEC_RST;
      dbg_en_q          <= 1'b0;
      load_q            <= 1'b1;
      load_cnt_q        <= `SCR_LOAD_WAIT;
      system_unlock_key <= `SCR_KEY_RST;
      key_written       <= 1'b0;
    end else begin
      key_written <= 1'b0;
      // Wait until the debug word has passed both sync flops, then load once
      if (load_cnt_q != `SCR_LOAD_DONE) begin
        load_cnt_q <= load_cnt_q - `SCR_LOAD_STEP;
      end else if (load_q) begin
        load_q   <= 1'b0;
        dbg_en_q <= dbg_cfg_q[`SCR_DBG_CFG_BIT];
      end
      if (wr && !err_d) begin
        case (addr)
          `SCR_OFF_CFG_CTRL: begin
            ram_exec_q <= pwdata[`SCR_EXEC_HI:`SCR_EXEC_LO];
            dbg_en_q   <= pwdata[`SCR_DBG_EN_BIT];
          end
          `SCR_OFF_UNLOCK_KEY: begin
            system_unlock_key <= pwdata;
            key_written       <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Outputs derived from the register state
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      startup_src       <= `SCR_SRC_FRC_DIV;
      code_protect_en   <= 1'b0;
      ram_exec_base     <= `SCR_RAM_BASE;
      debug_port_enable <= 1'b0;
    end else begin
      startup_src       <= src_d;
      code_protect_en   <= ~prot_q[`SCR_PROTECT_BIT];
      ram_exec_base     <= `SCR_RAM_BASE
                           + ({24'h000000, ram_exec_q} << `SCR_KB_SHIFT);
      debug_port_enable <= dbg_en_q;
    end
  end

endmodule
`default_nettype wire

// *** scr_regs_tb.sv ***
// Bench for the system configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h", $time, a); end end
module scr_regs_tb;
  logic        mclk = '0, rst_n = '0, psel = '0, penable = '0, pwrite = '0, er, kw;
  logic        pready, pslverr, code_protect_en, debug_port_enable, key_written;
  logic [2:0]  startup_src;
  logic [31:0] paddr = '0, pwdata = '0, prdata, ram_exec_base, system_unlock_key, rd;
  logic [31:0] osc_select_config_word = '0, code_protect_word = '1, debug_config_word = '0;
  int          fails = 0, n_compared = 0;
  scr_regs i_dut (
    .mclk                   (mclk),
    .rst_n                  (rst_n),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .osc_select_config_word (osc_select_config_word),
    .code_protect_word      (code_protect_word),
    .debug_config_word      (debug_config_word),
    .startup_src            (startup_src),
    .code_protect_en        (code_protect_en),
    .ram_exec_base          (ram_exec_base),
    .debug_port_enable      (debug_port_enable),
    .system_unlock_key      (system_unlock_key),
    .key_written            (key_written)
  );
  // Clock
  always #5 mclk = ~mclk;
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge mclk) {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge mclk) penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    kw = key_written;
    {psel, penable} <= 2'h0;
  endtask
  task automatic test_done;
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Reset with a given debug default and check the load
  task automatic t_reset(input logic b);
    @(posedge mclk) {rst_n, debug_config_word} <= {1'h0, 29'h0, b, 2'h0};
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (6) @(negedge mclk);
    `CHK(debug_port_enable, b)
    `CHK({ram_exec_base, system_unlock_key}, {32'hA0000000, 32'h0})
  endtask
  // Control writes, identity and key access, unmapped access
  task automatic t_regs;
    logic [31:0] v[3] = '{32'h00FF0000, 32'h00000008, 32'h00020000};
    foreach (v[i]) begin
      apb(1'h1, 32'h3B00, v[i]);
      `CHK({er, kw}, 2'h0)
      repeat (3) @(negedge mclk);
      `CHK(ram_exec_base, 32'hA0000000 + {v[i][23:16], 10'h0})
      `CHK(debug_port_enable, v[i][3])
      apb(1'h0, 32'h3B00, 32'h0);
      `CHK({er, rd[23:3]}, {1'h0, v[i][23:3]})
    end
    apb(1'h1, 32'h3B20, 32'hFFFFFFFF);
    apb(1'h0, 32'h3B20, 32'h0);
    `CHK(rd, {4'h1, 28'h0000ABC})
    apb(1'h1, 32'h3B30, 32'h5A5AC3C3);
    `CHK({er, kw}, 2'h1)
    apb(1'h0, 32'h3B30, 32'h0);
    `CHK({er, rd}, {1'h0, 32'h0})
    apb(1'h0, 32'h3B3C, 32'h0);
    `CHK({er, system_unlock_key}, {1'h1, 32'h5A5AC3C3})
  endtask
  // Every oscillator code with both references; the protect bit follows the code's low bit
  task automatic t_osc;
    logic [2:0] e[8] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h4, 3'h5, 3'h0, 3'h0};
    logic [2:0] x;
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk) osc_select_config_word <= {27'h0, i[3], 1'h0, i[2:0]};
      code_protect_word <= {i[0], 31'h7FFFFFFF};
      x = i[2:0] == 3'h1 && !i[3] ? 3'h2 : e[i[2:0]];
      repeat (6) @(negedge mclk);
      `CHK(startup_src, x)
      `CHK(code_protect_en, !i[0])
      apb(1'h0, 32'h3B48, 32'h0);
      `CHK({er, rd}, {1'h0, 29'h0, x})
      apb(1'h0, 32'h3B44, 32'h0);
      `CHK({er, rd}, {1'h0, i[0], 31'h7FFFFFFF})
    end
  endtask
  // Scenarios, with a second reset at the end of the run
  initial begin
    t_reset(1'h1);
    t_regs;
    t_osc;
    t_reset(1'h0);
    test_done;
  end
  // Watchdog
  initial begin
    #20000;
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
